// ==== verilog/flash_host_pkg.sv ====
`default_nettype none
package flash_host_pkg;
  // Widths of the flash pins, the operation code and the internal counters
  localparam int FA_W   = 19;
  localparam int FD_W   = 8;
  localparam int OP_W   = 4;
  localparam int CNT_W  = 4;
  localparam int GAP_W  = 12;
  localparam int PAIR_W = 11;
  localparam int STEP_W = 3;

  // Bus timing at 10 MHz
  localparam int CLK_NS      = 100;
  localparam int TWP_NS      = 35;
  localparam int TACC_NS     = 90;
  localparam int SYNC_STAGES = 2;
  localparam int WP_CYC      = (TWP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC     = (TACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_CYC      = ACC_CYC + SYNC_STAGES;
  localparam logic [CNT_W-1:0] WP_LAST = CNT_W'(WP_CYC - 1);
  localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_CYC - 1);

  // Suspend pacing
  localparam int RESUME_GAP_US = 400;
  localparam int GAP_CYC       = RESUME_GAP_US * 1000 / CLK_NS;
  localparam logic [GAP_W-1:0]  GAP_LD   = GAP_W'(GAP_CYC);
  localparam logic [PAIR_W-1:0] PAIR_MAX = PAIR_W'(1024);

  // Command addresses and codes
  localparam logic [FA_W-1:0] ADDR_UNLOCK1 = 19'h00555;
  localparam logic [FA_W-1:0] ADDR_UNLOCK2 = 19'h002AA;
  localparam logic [FD_W-1:0] DATA_UNLOCK1 = 8'hAA;
  localparam logic [FD_W-1:0] DATA_UNLOCK2 = 8'h55;
  localparam logic [FD_W-1:0] CODE_RESET   = 8'hF0;
  localparam logic [FD_W-1:0] CODE_ID      = 8'h90;
  localparam logic [FD_W-1:0] CODE_PROG    = 8'hA0;
  localparam logic [FD_W-1:0] CODE_ERASE   = 8'h80;
  localparam logic [FD_W-1:0] CODE_CHIP    = 8'h10;
  localparam logic [FD_W-1:0] CODE_SECTOR  = 8'h30;
  localparam logic [FD_W-1:0] CODE_SUSPEND = 8'hB0;
  localparam logic [FD_W-1:0] CODE_RESUME  = 8'h30;
  localparam int TOGGLE_POS = 6;

  // Operations software may order
  localparam logic [OP_W-1:0] OP_RESET    = 4'h0;
  localparam logic [OP_W-1:0] OP_ID       = 4'h1;
  localparam logic [OP_W-1:0] OP_PROG     = 4'h2;
  localparam logic [OP_W-1:0] OP_CHIP     = 4'h3;
  localparam logic [OP_W-1:0] OP_SECT     = 4'h4;
  localparam logic [OP_W-1:0] OP_SECT_ADD = 4'h5;
  localparam logic [OP_W-1:0] OP_SUSP     = 4'h6;
  localparam logic [OP_W-1:0] OP_RESUME   = 4'h7;
  localparam logic [OP_W-1:0] OP_READ     = 4'h8;

  // Register map and status fields
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam int ST_BUSY   = 0;
  localparam int ST_ERR    = 1;
  localparam int ST_TOGGLE = 2;
  localparam int ST_RD_LSB = 8;
  localparam int ST_PR_LSB = 16;

  typedef enum logic [1:0] {
    ENG_IDLE    = 2'b00,
    ENG_SETUP   = 2'b01,
    ENG_STROBE  = 2'b10,
    ENG_RELEASE = 2'b11
  } eng_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_ISSUE = 2'b01,
    SEQ_WAIT  = 2'b10
  } seq_state_t;
endpackage : flash_host_pkg
`default_nettype wire

// ==== verilog/flash_cycle_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface flash_cycle_if;
  import flash_host_pkg::*;
  logic            req;
  logic            wr;
  logic [FA_W-1:0] addr;
  logic [FD_W-1:0] wdata;
  logic            ack;
  logic [FD_W-1:0] rdata;
  modport seq (output req, output wr, output addr, output wdata,
               input ack, input rdata);
  modport eng (input req, input wr, input addr, input wdata,
               output ack, output rdata);
endinterface : flash_cycle_if
`default_nettype wire

// ==== verilog/flash_cycle_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_cycle_engine
  import flash_host_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rstn,
  flash_cycle_if.eng           cyc,
  input  wire logic [FD_W-1:0] fl_dq_in,
  output logic      [FA_W-1:0] fl_addr,
  output logic      [FD_W-1:0] fl_dq_out,
  output logic                 fl_dq_oe,
  output logic                 fl_ce_n,
  output logic                 fl_we_n,
  output logic                 fl_oe_n
);
  localparam int WP_HOLD = WP_CYC;

  eng_state_t      state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [FA_W-1:0] addr_ff, nxt_addr;
  logic [FD_W-1:0] dout_ff, nxt_dout, rdata_ff, nxt_rdata;
  logic [FD_W-1:0] dq_meta_ff, dq_sync_ff;
  logic            doe_ff, nxt_doe, wr_ff, nxt_wr, ack_ff, nxt_ack;
  logic            ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n;
  logic            oe_n_ff, nxt_oe_n;

  // Pins and answers straight from flops
  assign fl_addr   = addr_ff;
  assign fl_dq_out = dout_ff;
  assign fl_dq_oe  = doe_ff;
  assign fl_ce_n   = ce_n_ff;
  assign fl_we_n   = we_n_ff;
  assign fl_oe_n   = oe_n_ff;
  assign cyc.ack   = ack_ff;
  assign cyc.rdata = rdata_ff;

  // One bus cycle: setup, strobe, release with data still driven
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_addr  = addr_ff;
    nxt_dout  = dout_ff;
    nxt_rdata = rdata_ff;
    nxt_doe   = doe_ff;
    nxt_wr    = wr_ff;
    nxt_ce_n  = ce_n_ff;
    nxt_we_n  = we_n_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_ack   = 1'b0;
    unique case (state_ff)
      ENG_IDLE: begin
        if (cyc.req) begin
          nxt_state = ENG_SETUP;
          nxt_addr  = cyc.addr;
          nxt_dout  = cyc.wdata;
          nxt_wr    = cyc.wr;
          nxt_doe   = cyc.wr;
          nxt_ce_n  = 1'b0;
        end
      end
      ENG_SETUP: begin
        // Address settled a full cycle before the strobe
        nxt_state = ENG_STROBE;
        nxt_cnt   = '0;
        if (wr_ff) begin
          nxt_we_n = 1'b0;
        end else begin
          nxt_oe_n = 1'b0;
        end
      end
      ENG_STROBE: begin
        nxt_cnt = cnt_ff + 1'b1;
        if ((wr_ff && cnt_ff == WP_LAST)
            || (!wr_ff && cnt_ff == RD_LAST)) begin
          nxt_state = ENG_RELEASE;
          nxt_ce_n  = 1'b1;
          nxt_we_n  = 1'b1;
          nxt_oe_n  = 1'b1;
          if (!wr_ff) begin
            nxt_rdata = dq_sync_ff;
          end
        end
      end
      ENG_RELEASE: begin
        // Data dropped one cycle after the strobes rise
        nxt_state = ENG_IDLE;
        nxt_doe   = 1'b0;
        nxt_ack   = 1'b1;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ENG_IDLE;
      cnt_ff   <= '0;
      addr_ff  <= '0;
      dout_ff  <= '0;
      rdata_ff <= '0;
      doe_ff   <= 1'b0;
      wr_ff    <= 1'b0;
      ce_n_ff  <= 1'b1;
      we_n_ff  <= 1'b1;
      oe_n_ff  <= 1'b1;
      ack_ff   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      addr_ff  <= nxt_addr;
      dout_ff  <= nxt_dout;
      rdata_ff <= nxt_rdata;
      doe_ff   <= nxt_doe;
      wr_ff    <= nxt_wr;
      ce_n_ff  <= nxt_ce_n;
      we_n_ff  <= nxt_we_n;
      oe_n_ff  <= nxt_oe_n;
      ack_ff   <= nxt_ack;
    end
  end

  // Data pins are asynchronous to mclk
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dq_meta_ff <= '0;
      dq_sync_ff <= '0;
    end else begin
      dq_meta_ff <= fl_dq_in;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  write_qualify_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    !we_n_ff |-> !ce_n_ff && oe_n_ff && doe_ff)
    else $error("write strobe without select or with output enable");

  strobe_width_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    $fell(we_n_ff) |-> !we_n_ff ##WP_HOLD we_n_ff && ce_n_ff && doe_ff)
    else $error("write strobe width or data hold wrong");

  read_no_write_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    !oe_n_ff |-> we_n_ff && !doe_ff)
    else $error("output enable low while writing");
endmodule : flash_cycle_engine
`default_nettype wire

// ==== verilog/flash_host_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
  import flash_host_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            rstn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [FD_W-1:0] fl_dq_in,
  output logic      [FA_W-1:0] fl_addr,
  output logic      [FD_W-1:0] fl_dq_out,
  output logic                 fl_dq_oe,
  output logic                 fl_ce_n,
  output logic                 fl_we_n,
  output logic                 fl_oe_n
);
  // Number of bus writes or reads an operation needs
  function automatic logic [STEP_W-1:0] seq_len(input logic [OP_W-1:0] op);
    case (op)
      OP_ID:            seq_len = 3'd3;
      OP_PROG:          seq_len = 3'd4;
      OP_CHIP, OP_SECT: seq_len = 3'd6;
      default:          seq_len = 3'd1;
    endcase
  endfunction : seq_len

  // Address and data of one step of an operation
  function automatic logic [FA_W+FD_W-1:0] seq_word(
    input logic [OP_W-1:0]   op,
    input logic [STEP_W-1:0] idx,
    input logic [FA_W-1:0]   a,
    input logic [FD_W-1:0]   d);
    logic [FD_W-1:0] code;
    code = CODE_ERASE;
    if (seq_len(op) == 3'd1) begin
      case (op)
        OP_RESET:    code = CODE_RESET;
        OP_SECT_ADD: code = CODE_SECTOR;
        OP_SUSP:     code = CODE_SUSPEND;
        OP_RESUME:   code = CODE_RESUME;
        default:     code = 8'h00;
      endcase
      seq_word = {a, code};
    end else begin
      case (idx)
        3'd0, 3'd3: seq_word = {ADDR_UNLOCK1, DATA_UNLOCK1};
        3'd1, 3'd4: seq_word = {ADDR_UNLOCK2, DATA_UNLOCK2};
        3'd2: begin
          if (op == OP_ID) code = CODE_ID;
          else if (op == OP_PROG) code = CODE_PROG;
          seq_word = {ADDR_UNLOCK1, code};
        end
        default: begin
          if (op == OP_CHIP) seq_word = {ADDR_UNLOCK1, CODE_CHIP};
          else seq_word = {a, CODE_SECTOR};
        end
      endcase
      if (op == OP_PROG && idx == 3'd3) seq_word = {a, d};
    end
  endfunction : seq_word

  flash_cycle_if cyc ();

  seq_state_t        state_ff, nxt_state;
  logic [OP_W-1:0]   op_ff, nxt_op;
  logic [STEP_W-1:0] step_ff, nxt_step;
  logic [FA_W-1:0]   addr_ff, nxt_addr, cyc_addr_ff, nxt_cyc_addr;
  logic [FD_W-1:0]   wdata_ff, nxt_wdata, cyc_data_ff, nxt_cyc_data;
  logic [FD_W-1:0]   rd_ff, nxt_rd;
  logic              req_ff, nxt_req, cyc_wr_ff, nxt_cyc_wr;
  logic              err_ff, nxt_err, tog_ff, nxt_tog;
  logic              prev_tog_ff, nxt_prev_tog;
  logic [GAP_W-1:0]  gap_ff, nxt_gap;
  logic [PAIR_W-1:0] pairs_ff, nxt_pairs;
  logic [31:0]       prdata_ff, nxt_prdata;
  logic              pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic              access, known, take_wr, start, last_step;
  logic [OP_W-1:0]   new_op;

  assign cyc.req   = req_ff;
  assign cyc.wr    = cyc_wr_ff;
  assign cyc.addr  = cyc_addr_ff;
  assign cyc.wdata = cyc_data_ff;
  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;

  // APB decode; answer in the second access cycle
  assign access  = psel && penable;
  assign known   = paddr == REG_CTRL || paddr == REG_ADDR
                || paddr == REG_WDATA || paddr == REG_STATUS;
  assign take_wr = access && pready_ff && pwrite && !pslverr_ff;
  assign new_op  = pwdata[OP_W-1:0];
  assign start   = take_wr && paddr == REG_CTRL && state_ff == SEQ_IDLE
                && new_op <= OP_READ
                && !(new_op == OP_SUSP
                     && (gap_ff != '0 || pairs_ff == PAIR_MAX));
  assign last_step = step_ff == 3'(seq_len(op_ff) - 3'd1);

  always_comb begin
    nxt_pready  = access && !pready_ff;
    nxt_pslverr = access && !pready_ff && !known;
    nxt_prdata  = prdata_ff;
    if (access && !pready_ff && !pwrite) begin
      nxt_prdata = '0;
      case (paddr)
        REG_CTRL:  nxt_prdata[OP_W-1:0] = op_ff;
        REG_ADDR:  nxt_prdata[FA_W-1:0] = addr_ff;
        REG_WDATA: nxt_prdata[FD_W-1:0] = wdata_ff;
        REG_STATUS: begin
          nxt_prdata[ST_BUSY]   = state_ff != SEQ_IDLE;
          nxt_prdata[ST_ERR]    = err_ff;
          nxt_prdata[ST_TOGGLE] = tog_ff;
          nxt_prdata[ST_RD_LSB +: FD_W]   = rd_ff;
          nxt_prdata[ST_PR_LSB +: PAIR_W] = pairs_ff;
        end
        default: nxt_prdata = '0;
      endcase
    end
  end

  // Operation sequencer
  always_comb begin
    nxt_state    = state_ff;
    nxt_op       = op_ff;
    nxt_step     = step_ff;
    nxt_addr     = addr_ff;
    nxt_wdata    = wdata_ff;
    nxt_cyc_addr = cyc_addr_ff;
    nxt_cyc_data = cyc_data_ff;
    nxt_cyc_wr   = cyc_wr_ff;
    nxt_req      = 1'b0;
    nxt_err      = err_ff;
    nxt_rd       = rd_ff;
    nxt_tog      = tog_ff;
    nxt_prev_tog = prev_tog_ff;
    nxt_pairs    = pairs_ff;
    nxt_gap      = (gap_ff != '0) ? gap_ff - 1'b1 : gap_ff;
    if (take_wr && paddr == REG_ADDR) nxt_addr = pwdata[FA_W-1:0];
    if (take_wr && paddr == REG_WDATA) nxt_wdata = pwdata[FD_W-1:0];
    // Refused orders leave a sticky error until the next accepted one
    if (start) begin
      nxt_op    = new_op;
      nxt_step  = '0;
      nxt_err   = 1'b0;
      nxt_state = SEQ_ISSUE;
    end else if (take_wr && paddr == REG_CTRL) begin
      nxt_err = 1'b1;
    end
    unique case (state_ff)
      SEQ_IDLE: ;
      SEQ_ISSUE: begin
        nxt_req = 1'b1;
        {nxt_cyc_addr, nxt_cyc_data} =
          seq_word(op_ff, step_ff, addr_ff, wdata_ff);
        nxt_cyc_wr = op_ff != OP_READ;
        nxt_state  = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (cyc.ack) begin
          nxt_step  = step_ff + 1'b1;
          nxt_state = last_step ? SEQ_IDLE : SEQ_ISSUE;
          if (last_step && op_ff == OP_READ) begin
            // Two reads differing in the toggle bit mean still busy
            nxt_rd       = cyc.rdata;
            nxt_tog      = cyc.rdata[TOGGLE_POS] ^ prev_tog_ff;
            nxt_prev_tog = cyc.rdata[TOGGLE_POS];
          end
          if (last_step && op_ff == OP_RESUME) begin
            nxt_gap = GAP_LD;
            if (pairs_ff != PAIR_MAX) nxt_pairs = pairs_ff + 1'b1;
          end
          if (last_step && (op_ff == OP_CHIP || op_ff == OP_SECT))
            nxt_pairs = '0;
        end
      end
      default: nxt_state = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= SEQ_IDLE;
      op_ff       <= OP_RESET;
      step_ff     <= '0;
      addr_ff     <= '0;
      wdata_ff    <= '0;
      cyc_addr_ff <= '0;
      cyc_data_ff <= '0;
      cyc_wr_ff   <= 1'b0;
      req_ff      <= 1'b0;
      err_ff      <= 1'b0;
      rd_ff       <= '0;
      tog_ff      <= 1'b0;
      prev_tog_ff <= 1'b0;
      gap_ff      <= '0;
      pairs_ff    <= '0;
      prdata_ff   <= '0;
      pready_ff   <= 1'b0;
      pslverr_ff  <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      op_ff       <= nxt_op;
      step_ff     <= nxt_step;
      addr_ff     <= nxt_addr;
      wdata_ff    <= nxt_wdata;
      cyc_addr_ff <= nxt_cyc_addr;
      cyc_data_ff <= nxt_cyc_data;
      cyc_wr_ff   <= nxt_cyc_wr;
      req_ff      <= nxt_req;
      err_ff      <= nxt_err;
      rd_ff       <= nxt_rd;
      tog_ff      <= nxt_tog;
      prev_tog_ff <= nxt_prev_tog;
      gap_ff      <= nxt_gap;
      pairs_ff    <= nxt_pairs;
      prdata_ff   <= nxt_prdata;
      pready_ff   <= nxt_pready;
      pslverr_ff  <= nxt_pslverr;
    end
  end

  flash_cycle_engine engine (
    .mclk      (mclk),
    .rstn      (rstn),
    .cyc       (cyc.eng),
    .fl_dq_in  (fl_dq_in),
    .fl_addr   (fl_addr),
    .fl_dq_out (fl_dq_out),
    .fl_dq_oe  (fl_dq_oe),
    .fl_ce_n   (fl_ce_n),
    .fl_we_n   (fl_we_n),
    .fl_oe_n   (fl_oe_n)
  );

  unlock_first_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    req_ff && seq_len(op_ff) > 3'd1 && (step_ff == 3'd0 || step_ff == 3'd3)
      && !(op_ff == OP_PROG && step_ff == 3'd3)
    |-> cyc_addr_ff == ADDR_UNLOCK1 && cyc_data_ff == DATA_UNLOCK1)
    else $error("first unlock write wrong");

  unlock_second_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    req_ff && seq_len(op_ff) > 3'd1 && (step_ff == 3'd1 || step_ff == 3'd4)
    |-> cyc_addr_ff == ADDR_UNLOCK2 && cyc_data_ff == DATA_UNLOCK2)
    else $error("second unlock write wrong");

  program_code_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    req_ff && op_ff == OP_PROG && step_ff == 3'd2
    |-> cyc_data_ff == CODE_PROG ##[1:20] req_ff && cyc_addr_ff == addr_ff
        && cyc_data_ff == wdata_ff)
    else $error("program command or target byte wrong");

  chip_confirm_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    req_ff && op_ff == OP_CHIP && step_ff == 3'd5
    |-> cyc_addr_ff == ADDR_UNLOCK1 && cyc_data_ff == CODE_CHIP)
    else $error("chip erase confirm write wrong");

  sector_confirm_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    req_ff && (op_ff == OP_SECT && step_ff == 3'd5 || op_ff == OP_SECT_ADD)
    |-> cyc_addr_ff == addr_ff && cyc_data_ff == CODE_SECTOR)
    else $error("sector erase write wrong");

  suspend_spacing_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    state_ff == SEQ_IDLE ##1 state_ff == SEQ_ISSUE && op_ff == OP_SUSP
    |-> $past(gap_ff) == '0 && $past(pairs_ff) != PAIR_MAX)
    else $error("suspend issued too soon or past pair limit");

  resume_load_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    state_ff == SEQ_WAIT && cyc.ack && op_ff == OP_RESUME && last_step
    |=> gap_ff == GAP_LD ##1 gap_ff == GAP_LD - 1'b1)
    else $error("resume spacing not started");

  legal_op_a: assert property (
    @(posedge mclk) disable iff (!rstn)
    state_ff != SEQ_IDLE |-> op_ff <= OP_READ && step_ff < seq_len(op_ff))
    else $error("undefined operation on the flash bus");
endmodule : flash_host_ctrl
`default_nettype wire

// ==== tb/flash_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_ID   = 8'h3C, // Arbitrary value
  parameter int         PROG_NS  = 20000,
  parameter int         WIN_NS   = 50000,
  parameter int         ERASE_NS = 30000
) (
  input  wire logic [18:0] fl_addr,
  input  wire logic [7:0]  fl_dq_out,
  input  wire logic        fl_dq_oe,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_oe_n,
  output logic      [7:0]  fl_dq_in
);
  typedef enum logic [2:0] {
    M_ARR, M_ID, M_PROG, M_WIN, M_ERASE, M_SUSP
  } mode_t;
  mode_t       mode = M_ARR;
  int          step = 0;
  logic [7:0]  mem [0:255];
  logic [7:0]  sect = 8'h00;
  logic [7:0]  pd = 8'h00;
  logic [7:0]  q = 8'h00;
  logic [18:0] wa;
  logic        wr_ok, tog = 1'b0, tog2 = 1'b0, susp = 1'b0, chip = 1'b0;
  time         t_end, t_left;

  // Small array: sector bits plus low address bits
  function automatic logic [7:0] idx(input logic [18:0] a);
    return {a[18:16], a[4:0]};
  endfunction : idx

  initial foreach (mem[i]) mem[i] = 8'hFF;

  // Timed phases resolved lazily at each pin access
  task automatic tick();
    if (mode == M_PROG && $time >= t_end)
      mode = susp ? M_SUSP : M_ARR;
    if (mode == M_WIN && $time >= t_end) begin
      mode = M_ERASE;
      t_end = t_end + ERASE_NS;
    end
    if (mode == M_ERASE && $time >= t_end) begin
      for (int i = 0; i < 256; i++) if (sect[i[7:5]]) mem[i] = 8'hFF;
      mode = M_ARR;
    end
  endtask : tick

  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    tick();
    if (mode == M_PROG) return;
    if (mode == M_ERASE) begin
      if (chip || d != 8'hB0) return;
      t_left = t_end - $time;
      mode = M_SUSP;
      susp = 1'b1;
      return;
    end
    if (mode == M_WIN) begin
      if (d == 8'h30) begin
        sect[a[18:16]] = 1'b1;
        t_end = $time + WIN_NS;
      end else if (d == 8'hB0) begin
        t_left = ERASE_NS;
        mode = M_SUSP;
        susp = 1'b1;
      end else mode = M_ARR;
      return;
    end
    if (d == 8'hF0) begin
      mode = susp ? M_SUSP : M_ARR;
      step = 0;
      return;
    end
    if (mode == M_SUSP && step == 0 && d == 8'h30) begin
      mode = M_ERASE;
      susp = 1'b0;
      t_end = $time + t_left;
      return;
    end
    case (step)
      0: step = (a[10:0] == 11'h555 && d == 8'hAA) ? 1 : 0;
      1: step = (a[10:0] == 11'h2AA && d == 8'h55) ? 2 : 0;
      2: begin
        step = 0;
        if (a[10:0] == 11'h555 && d == 8'h90) mode = M_ID;
        if (a[10:0] == 11'h555 && d == 8'hA0) step = 3;
        if (a[10:0] == 11'h555 && d == 8'h80 && !susp) step = 4;
      end
      3: begin
        mem[idx(a)] = mem[idx(a)] & d;
        pd = d;
        mode = M_PROG;
        t_end = $time + PROG_NS;
        step = 0;
      end
      4: step = (a[10:0] == 11'h555 && d == 8'hAA) ? 5 : 0;
      5: step = (a[10:0] == 11'h2AA && d == 8'h55) ? 6 : 0;
      default: begin
        step = 0;
        chip = (d == 8'h10 && a[10:0] == 11'h555);
        sect = chip ? 8'hFF : 8'h00;
        if (d == 8'h30) sect[a[18:16]] = 1'b1;
        if (chip || d == 8'h30) mode = chip ? M_ERASE : M_WIN;
        t_end = $time + (chip ? ERASE_NS : WIN_NS);
      end
    endcase
  endtask : cmd

  // Address on falling strobe, data on rising strobe
  always @(negedge fl_we_n) begin
    wr_ok = fl_ce_n === 1'b0 && fl_oe_n === 1'b1;
    wa = fl_addr;
  end
  // Data only counts while the host drives the data pins
  always @(posedge fl_we_n) begin
    if (wr_ok && fl_dq_oe === 1'b1) cmd(wa, fl_dq_out);
  end

  // Read answer; status bits toggle once per read
  always @(negedge fl_oe_n) if (fl_ce_n === 1'b0) begin
    tick();
    tog = tog ^ (mode inside {M_PROG, M_WIN, M_ERASE});
    tog2 = ~tog2;
    case (mode)
      M_ID: q = fl_addr[0] ? DEV_ID : MAKER_ID;
      M_PROG: q = {~pd[7], tog, 6'h00};
      M_WIN, M_ERASE:
        q = {1'b0, tog, 2'b00, mode == M_ERASE, tog2, 2'b00};
      M_SUSP:
        q = sect[fl_addr[18:16]] ? {1'b1, tog, 3'b000, tog2, 2'b00}
                                 : mem[idx(fl_addr)];
      default: q = mem[idx(fl_addr)];
    endcase
  end
  // Released or contended pins show the inverse: no pull resistors
  assign fl_dq_in = (fl_oe_n === 1'b0 && fl_ce_n === 1'b0
                     && fl_dq_oe === 1'b0) ? q : ~q;
endmodule : flash_dev_model
`default_nettype wire

// ==== tb/parallel_flash_command_sequencer_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module parallel_flash_command_sequencer_tb;
  import flash_host_pkg::*;
  localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEVID = 8'h3C; // Arbitrary value
  logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, last_err;
  logic [7:0]  paddr, dq_in, dq_out;
  logic [31:0] pwdata, prdata, st, q;
  logic [18:0] fl_addr;
  logic        ce_n, we_n, oe_n, dq_oe;
  int          err_count, compares;

  flash_host_ctrl flash_host_ctrl_inst (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_dq_in(dq_in),
    .fl_addr(fl_addr), .fl_dq_out(dq_out), .fl_dq_oe(dq_oe), .fl_ce_n(ce_n),
    .fl_we_n(we_n), .fl_oe_n(oe_n));
  flash_dev_model #(.MAKER_ID(MAKER), .DEV_ID(DEVID)) flash_dev_model_inst (
    .fl_addr(fl_addr), .fl_dq_out(dq_out), .fl_dq_oe(dq_oe), .fl_ce_n(ce_n),
    .fl_we_n(we_n), .fl_oe_n(oe_n), .fl_dq_in(dq_in));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // One APB transfer; waits for pready however long it takes
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask : chk8

  // Order one operation, then poll until the host is idle
  task automatic op(input logic [3:0] o, input logic [18:0] a,
                    input logic [7:0] d);
    bus(1'b1, REG_ADDR, 32'(a));
    bus(1'b1, REG_WDATA, 32'(d));
    bus(1'b1, REG_CTRL, 32'(o));
    do begin
      bus(1'b0, REG_STATUS, 32'h0);
      st = q;
    end while (st[ST_BUSY] !== 1'b0);
  endtask : op

  // Read at least twice, until the toggle bit stands still
  task automatic settle(input logic [18:0] a);
    int n;
    n = 0;
    do begin
      op(OP_READ, a, 8'h00);
      n++;
    end while ((st[ST_TOGGLE] !== 1'b0 || n < 2) && n < 300);
  endtask : settle

  task automatic summarize();
    $display("Mismatches %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    err_count = 0;
    compares = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    bus(1'b0, 8'h10, 32'h0);
    chk8({q[7:0] | 8'(!last_err)}, 8'h00);
    op(OP_READ, 19'h00123, 8'h00);
    chk8(st[15:8], 8'hFF);
    op(OP_ID, 19'h00000, 8'h00);
    op(OP_READ, 19'h00000, 8'h00);
    chk8(st[15:8], MAKER);
    op(OP_READ, 19'h40001, 8'h00);
    chk8(st[15:8], DEVID);
    op(OP_RESET, 19'h00000, 8'h00);
    op(OP_READ, 19'h00001, 8'h00);
    chk8(st[15:8], 8'hFF);
    op(OP_PROG, 19'h10005, 8'h3C);
    op(OP_READ, 19'h10005, 8'h00);
    chk8(st[15:8] & 8'hA0, 8'h80);
    op(OP_RESET, 19'h00000, 8'h00);
    op(OP_READ, 19'h10005, 8'h00);
    chk8({7'h0, st[ST_TOGGLE]}, 8'h01);
    settle(19'h10005);
    chk8(st[15:8], 8'h3C);
    op(OP_PROG, 19'h10005, 8'hC3);
    settle(19'h10005);
    chk8(st[15:8], 8'h00);
    op(OP_SECT, 19'h10000, 8'h00);
    op(OP_READ, 19'h10005, 8'h00);
    chk8(st[15:8] & 8'hA8, 8'h00);
    op(OP_SECT_ADD, 19'h20000, 8'h00);
    op(OP_SUSP, 19'h10000, 8'h00);
    op(OP_READ, 19'h20005, 8'h00);
    op(OP_READ, 19'h10005, 8'h00);
    chk8((st[15:8] & 8'hA0) | 8'(st[ST_TOGGLE]), 8'h80);
    op(OP_READ, 19'h30005, 8'h00);
    chk8(st[15:8], 8'hFF);
    op(OP_CHIP, 19'h00000, 8'h00);
    op(OP_READ, 19'h10005, 8'h00);
    chk8(st[15:8] & 8'h80, 8'h80);
    op(OP_RESUME, 19'h00000, 8'h00);
    op(OP_READ, 19'h10005, 8'h00);
    chk8(st[15:8] & 8'h88, 8'h08);
    op(OP_SUSP, 19'h10000, 8'h00);
    chk8({7'h0, st[ST_ERR]}, 8'h01);
    chk8(st[ST_PR_LSB +: 8], 8'h01);
    op(4'h9, 19'h00000, 8'h00);
    chk8({7'h0, st[ST_ERR]}, 8'h01);
    settle(19'h10005);
    chk8(st[15:8], 8'hFF);
    op(OP_SECT, 19'h20000, 8'h00);
    op(OP_RESET, 19'h00000, 8'h00);
    op(OP_READ, 19'h20005, 8'h00);
    chk8(st[15:8], 8'hFF);
    op(OP_PROG, 19'h00007, 8'h5A);
    settle(19'h00007);
    chk8(st[15:8], 8'h5A);
    op(OP_CHIP, 19'h00000, 8'h00);
    op(OP_RESET, 19'h00000, 8'h00);
    op(OP_READ, 19'h00007, 8'h00);
    chk8(st[15:8] & 8'h80, 8'h00);
    settle(19'h00007);
    chk8(st[15:8], 8'hFF);
    summarize();
  end

  // Whole run is well under a millisecond; cut a hang at three
  initial begin
    #3000000;
    err_count++;
    $display("BAD %0t run did not complete", $time);
    summarize();
  end
endmodule : parallel_flash_command_sequencer_tb
`default_nettype wire
